// >>> logic/timer_regs.sv
/*
  Register side of a four-subsystem timer: enables, W1C flags, prescalers,
  counters and double-buffered period/duty registers, one request per subsystem.
  Assumes an Avalon-MM master that holds its request until waitrequest is low,
  and capture pulses that are synchronous to clk and one cycle long.
*/
`timescale 1ns/10ps
module timer_regs (
  input  wire logic        clk,         // 40 MHz clock
  input  wire logic        rst_b,       // Synchronous reset, active low
  input  wire logic [9:0]  address,     // Avalon byte address
  input  wire logic        read,        // Avalon read
  input  wire logic        write,       // Avalon write
  input  wire logic [31:0] writedata,   // Avalon write data
  input  wire logic [3:0]  byteenable,  // Avalon byte lanes
  output logic      [31:0] readdata,    // Avalon read data
  output logic             waitrequest, // Avalon wait
  input  wire logic [3:0]  capture_a,   // Capture into period register
  input  wire logic [3:0]  capture_b,   // Capture into duty register
  output logic      [3:0]  irq          // One request per subsystem
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic             wt;
    logic [31:0]      rdata;
    logic [15:0]      mode;
    logic [15:0]      en;
    logic [15:0]      flags;
    logic [1:0][15:0] ps;
    logic [3:0][7:0]  pre;
    logic [3:0][15:0] cnt;
    logic [3:0][15:0] wper;
    logic [3:0][15:0] aper;
    logic [3:0][15:0] wduty;
    logic [3:0][15:0] aduty;
    logic [3:0]       irq;
  } state_s;

  localparam state_s RST_STATE = '{wt: 1'b1, default: '0};

  state_s      state_ff;
  state_s      nxt_state;
  logic [15:0] set_vec;
  logic [15:0] clr_vec;
  logic [3:0]  tick_vec;

  function automatic logic [15:0] merge(
    input logic [15:0] old,
    input logic [15:0] wd,
    input logic [15:0] wm
  );
    return (old & ~wm) | (wd & wm);
  endfunction : merge

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb
  begin
    logic [15:0]                 wm;
    logic [15:0]                 wd;
    logic [15:0]                 rd16;
    logic [timer_regs_pkg::IDX_W-1:0] idx;
    logic                        acc_wr;
    timer_regs_pkg::tmode_e      md;
    logic                        run_lo;
    logic                        run_hi;
    logic                        tick;
    logic                        upd_lo;
    logic                        upd_hi;
    logic [7:0]                  cmp;
    logic [1:0]                  mbits;
    int unsigned                 b;
    wm        = {{8{byteenable[1]}}, {8{byteenable[0]}}};
    wd        = writedata[15:0];
    rd16      = timer_regs_pkg::RD_NONE;
    idx       = address[timer_regs_pkg::ADDR_W-1:timer_regs_pkg::IDX_LSB];
    acc_wr    = !state_ff.wt && write;
    md        = timer_regs_pkg::MODE_OFF;
    run_lo    = 1'b0;
    run_hi    = 1'b0;
    tick      = 1'b0;
    upd_lo    = 1'b0;
    upd_hi    = 1'b0;
    cmp       = '0;
    mbits     = '0;
    b         = 0;
    nxt_state = state_ff;
    set_vec   = '0;
    clr_vec   = '0;
    tick_vec  = '0;

    // One wait cycle, then a single answer cycle per request
    nxt_state.wt = !(state_ff.wt && (read || write));

    // Read mux; unmapped indices read as zero
    if (idx == timer_regs_pkg::IDX_MODE)
      rd16 = state_ff.mode;
    if (idx == timer_regs_pkg::IDX_EN)
      rd16 = state_ff.en;
    if (idx == timer_regs_pkg::IDX_FLAGS)
      rd16 = state_ff.flags;
    if (idx == timer_regs_pkg::IDX_PS_A)
      rd16 = state_ff.ps[0];
    if (idx == timer_regs_pkg::IDX_PS_B)
      rd16 = state_ff.ps[1];
    for (int s = 0; s < timer_regs_pkg::NSUB; s++)
    begin
      if (idx == timer_regs_pkg::IDX_CNT[s])
        rd16 = state_ff.cnt[s];
      if (idx == timer_regs_pkg::IDX_PER[s])
        rd16 = state_ff.wper[s];
      if (idx == timer_regs_pkg::IDX_DUTY[s])
        rd16 = state_ff.wduty[s];
    end
    if (state_ff.wt && read)
      nxt_state.rdata = {16'h0000, rd16};

    // Shared control registers
    if (acc_wr)
    begin
      if (idx == timer_regs_pkg::IDX_MODE)
        nxt_state.mode = merge(state_ff.mode, wd, wm);
      if (idx == timer_regs_pkg::IDX_EN)
        nxt_state.en = merge(state_ff.en, wd, wm);
      if (idx == timer_regs_pkg::IDX_PS_A)
        nxt_state.ps[0] = merge(state_ff.ps[0], wd, wm);
      if (idx == timer_regs_pkg::IDX_PS_B)
        nxt_state.ps[1] = merge(state_ff.ps[1], wd, wm);
      if (idx == timer_regs_pkg::IDX_FLAGS)
        clr_vec = wd & wm;
    end

    // Per-subsystem counters
    for (int s = 0; s < timer_regs_pkg::NSUB; s++)
    begin
      b      = s * timer_regs_pkg::SUB_W;
      mbits  = state_ff.mode[b + timer_regs_pkg::MODE_LSB +: 2];
      md     = timer_regs_pkg::tmode_e'(mbits);
      // lower run bit only unless dual
      run_lo = (md != timer_regs_pkg::MODE_OFF) &&
               state_ff.mode[b + timer_regs_pkg::RUN_LO_BIT];
      run_hi = (md == timer_regs_pkg::MODE_DUAL) &&
               state_ff.mode[b + timer_regs_pkg::RUN_HI_BIT];
      cmp    = state_ff.ps[s / 2][(s % 2) * timer_regs_pkg::PS_W +: timer_regs_pkg::PS_W];
      tick   = 1'b0;
      if (run_lo || run_hi)
      begin
        if (state_ff.pre[s] == cmp)
        begin
          nxt_state.pre[s] = '0;
          tick = 1'b1;
        end
        else
          nxt_state.pre[s] = state_ff.pre[s] + 8'h01;
      end
      else
        nxt_state.pre[s] = '0;
      tick_vec[s] = tick;

      upd_lo = !run_lo;
      upd_hi = (md == timer_regs_pkg::MODE_DUAL) ? !run_hi : !run_lo;

      unique case (md)
        timer_regs_pkg::MODE_DUAL:
        begin
          if (tick && run_lo)
          begin
            if (state_ff.cnt[s][7:0] == state_ff.aduty[s][7:0])
              set_vec[b + timer_regs_pkg::FLAG_A] = 1'b1;
            if (state_ff.cnt[s][7:0] == state_ff.aper[s][7:0])
            begin
              nxt_state.cnt[s][7:0] = '0;
              set_vec[b + timer_regs_pkg::FLAG_B] = 1'b1;
              upd_lo = 1'b1;
            end
            else
              nxt_state.cnt[s][7:0] = state_ff.cnt[s][7:0] + 8'h01;
          end
          if (tick && run_hi)
          begin
            if (state_ff.cnt[s][15:8] == state_ff.aduty[s][15:8])
              set_vec[b + timer_regs_pkg::FLAG_C] = 1'b1;
            if (state_ff.cnt[s][15:8] == state_ff.aper[s][15:8])
            begin
              nxt_state.cnt[s][15:8] = '0;
              set_vec[b + timer_regs_pkg::FLAG_D] = 1'b1;
              upd_hi = 1'b1;
            end
            else
              nxt_state.cnt[s][15:8] = state_ff.cnt[s][15:8] + 8'h01;
          end
        end
        timer_regs_pkg::MODE_PWM16:
        begin
          if (tick && run_lo)
          begin
            if (state_ff.cnt[s] == state_ff.aduty[s])
              set_vec[b + timer_regs_pkg::FLAG_A] = 1'b1;
            if (state_ff.cnt[s] == state_ff.aper[s])
            begin
              nxt_state.cnt[s] = '0;
              set_vec[b + timer_regs_pkg::FLAG_B] = 1'b1;
              upd_lo = 1'b1;
              upd_hi = 1'b1;
            end
            else
              nxt_state.cnt[s] = state_ff.cnt[s] + 16'h0001;
          end
        end
        timer_regs_pkg::MODE_CAPTURE:
        begin
          if (tick && run_lo)
          begin
            nxt_state.cnt[s] = state_ff.cnt[s] + 16'h0001;
            if (state_ff.cnt[s] == timer_regs_pkg::CNT_MAX)
              set_vec[b + timer_regs_pkg::FLAG_C] = 1'b1;
          end
        end
        timer_regs_pkg::MODE_OFF:
        begin
          // Clocks stopped: active values are frozen too
          upd_lo = 1'b0;
          upd_hi = 1'b0;
        end
      endcase

      if (upd_lo)
      begin
        nxt_state.aper[s][7:0]  = state_ff.wper[s][7:0];
        nxt_state.aduty[s][7:0] = state_ff.wduty[s][7:0];
      end
      if (upd_hi)
      begin
        nxt_state.aper[s][15:8]  = state_ff.wper[s][15:8];
        nxt_state.aduty[s][15:8] = state_ff.wduty[s][15:8];
      end

      // Writes to a subsystem in low-power mode are dropped
      if (acc_wr && (md != timer_regs_pkg::MODE_OFF))
      begin
        // software writes the counter whether it runs or not; the write beats a count
        if (idx == timer_regs_pkg::IDX_CNT[s])
          nxt_state.cnt[s] = merge(state_ff.cnt[s], wd, wm);
        if (idx == timer_regs_pkg::IDX_PER[s])
          nxt_state.wper[s] = merge(state_ff.wper[s], wd, wm);
        if (idx == timer_regs_pkg::IDX_DUTY[s])
          nxt_state.wduty[s] = merge(state_ff.wduty[s], wd, wm);
      end

      // capture latches the count; capture beats a write
      if (md == timer_regs_pkg::MODE_CAPTURE)
      begin
        if (capture_a[s])
        begin
          nxt_state.wper[s] = state_ff.cnt[s];
          set_vec[b + timer_regs_pkg::FLAG_A] = 1'b1;
        end
        if (capture_b[s])
        begin
          nxt_state.wduty[s] = state_ff.cnt[s];
          set_vec[b + timer_regs_pkg::FLAG_B] = 1'b1;
        end
      end
    end

    // flags set regardless of enable, set beats clear
    nxt_state.flags = (state_ff.flags & ~clr_vec) | set_vec;

    for (int s = 0; s < timer_regs_pkg::NSUB; s++)
      nxt_state.irq[s] = |(nxt_state.flags[s * timer_regs_pkg::SUB_W +: timer_regs_pkg::SUB_W] &
                           nxt_state.en[s * timer_regs_pkg::SUB_W +: timer_regs_pkg::SUB_W]);
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge clk)
  begin
    if (!rst_b)
      state_ff <= RST_STATE;
    else
      state_ff <= nxt_state;
  end

  assign readdata    = state_ff.rdata;
  assign waitrequest = state_ff.wt;
  assign irq         = state_ff.irq;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  wait_pulse_a: assert property (!waitrequest |=> waitrequest)
    else $error("waitrequest low for more than one cycle");

  flag_masked_a: assert property (set_vec[0] && !state_ff.en[0] |=> state_ff.flags[0])
    else $error("disabled source did not set its flag");

  set_wins_a: assert property (set_vec[4] && clr_vec[4] |=> state_ff.flags[4])
    else $error("clear write lost a same-cycle event");

  w1c_clear_a: assert property (clr_vec[1] && !set_vec[1] |=> !state_ff.flags[1])
    else $error("flag not cleared by write of one");

  en_sw_only_a: assert property (
    !(write && !waitrequest && address[9:2] == timer_regs_pkg::IDX_EN)
    |=> $stable(state_ff.en))
    else $error("enable register changed without a write");

  irq_group_a: assert property (irq[1] == |(state_ff.flags[7:4] & state_ff.en[7:4]))
    else $error("request does not match flags and enables");

  presc_tick_a: assert property (tick_vec[2] |-> state_ff.pre[2] == state_ff.ps[1][7:0]
                                 ##1 state_ff.pre[2] == 8'h00)
    else $error("prescaler tick not on compare match");

  per_hold_a: assert property (
    state_ff.mode[7:4] == 4'h9 && !(tick_vec[1] && state_ff.cnt[1] == state_ff.aper[1])
    |=> $stable(state_ff.aper[1]))
    else $error("active period changed off a boundary");

  duty_hold_a: assert property (
    state_ff.mode[7:4] == 4'h9 && !(tick_vec[1] && state_ff.cnt[1] == state_ff.aper[1])
    |=> $stable(state_ff.aduty[1]))
    else $error("active duty changed off a boundary");

  cnt_read_a: assert property (
    read && waitrequest && address[9:2] == timer_regs_pkg::IDX_CNT[0]
    |=> readdata[15:0] == $past(state_ff.cnt[0]))
    else $error("counter read returned a stale value");

  per_read_a: assert property (
    read && waitrequest && address[9:2] == timer_regs_pkg::IDX_PER[1]
    |=> readdata[15:0] == $past(state_ff.wper[1]))
    else $error("period read did not return the written value");

  run_hi_only_a: assert property (
    state_ff.mode[3:0] == 4'he &&
    !(write && !waitrequest && address[9:2] == timer_regs_pkg::IDX_CNT[0])
    |=> $stable(state_ff.cnt[0]))
    else $error("counter advanced on the upper run bit");

endmodule : timer_regs

// >>> logic/timer_regs_pkg.sv
/*
  Constants for the four-subsystem timer register block: register indices,
  field positions, operating modes and reset values.
  Assumes an Avalon-MM slave with a byte address; byte address = 4 * index.
*/
package timer_regs_pkg;

  // ----------------------------------------
  // Bus geometry
  // ----------------------------------------
  localparam int unsigned ADDR_W  = 10;
  localparam int unsigned IDX_LSB = 2;
  localparam int unsigned IDX_W   = 8;
  localparam int unsigned NSUB    = 4;

  // ----------------------------------------
  // Register indices
  // ----------------------------------------
  localparam logic [7:0] IDX_MODE  = 8'h80;
  localparam logic [7:0] IDX_EN    = 8'h86;
  localparam logic [7:0] IDX_FLAGS = 8'h88;
  localparam logic [7:0] IDX_PS_A  = 8'h8a;
  localparam logic [7:0] IDX_PS_B  = 8'h98;
  localparam logic [3:0][7:0] IDX_CNT  = {8'ha0, 8'h9a, 8'h92, 8'h8c};
  localparam logic [3:0][7:0] IDX_PER  = {8'ha2, 8'h9c, 8'h94, 8'h8e};
  localparam logic [3:0][7:0] IDX_DUTY = {8'ha4, 8'h9e, 8'h96, 8'h90};

  // ----------------------------------------
  // Field layout
  // ----------------------------------------
  localparam int unsigned SUB_W      = 4;
  localparam int unsigned RUN_LO_BIT = 0;
  localparam int unsigned RUN_HI_BIT = 1;
  localparam int unsigned MODE_LSB   = 2;
  localparam int unsigned PS_W       = 8;
  localparam int unsigned FLAG_A     = 0;
  localparam int unsigned FLAG_B     = 1;
  localparam int unsigned FLAG_C     = 2;
  localparam int unsigned FLAG_D     = 3;

  // ----------------------------------------
  // Values
  // ----------------------------------------
  localparam logic [15:0] REG_RST = 16'h0000;
  localparam logic [15:0] CNT_MAX = 16'hffff;
  localparam logic [15:0] RD_NONE = 16'h0000;

  typedef enum logic [1:0] {
    MODE_OFF     = 2'b00,
    MODE_DUAL    = 2'b01,
    MODE_PWM16   = 2'b10,
    MODE_CAPTURE = 2'b11
  } tmode_e;

endpackage : timer_regs_pkg

// >>> testbench/tb_top.sv
/*
  Self-checking bench for the four-subsystem timer register block.
  Assumes the design answers each Avalon request after one wait cycle
  and registers its interrupt lines in the same cycle as the flags.
*/
`timescale 1ns/10ps
module tb_top;

  typedef struct {
    logic [7:0]  idx;
    logic [15:0] wd;
    logic [15:0] ex;
  } row_s;

  logic        clk;
  logic        rst_b;
  logic [9:0]  address;
  logic        read;
  logic        write;
  logic [31:0] writedata;
  logic [3:0]  byteenable;
  logic [31:0] readdata;
  logic        waitrequest;
  logic [3:0]  capture_a;
  logic [3:0]  capture_b;
  logic [3:0]  irq;
  int          num_errors;
  int          n_compared;
  row_s        rows[18];
  logic [15:0] rd;
  logic [15:0] x3;
  logic [15:0] x4;
  logic [15:0] y3;
  logic [15:0] y4;

  timer_regs dut (
    .clk         (clk),
    .rst_b       (rst_b),
    .address     (address),
    .read        (read),
    .write       (write),
    .writedata   (writedata),
    .byteenable  (byteenable),
    .readdata    (readdata),
    .waitrequest (waitrequest),
    .capture_a   (capture_a),
    .capture_b   (capture_b),
    .irq         (irq)
  );

  always #12.5 clk = ~clk;

  // ----------------------------------------
  // Bus and compare tasks
  // ----------------------------------------
  // Each access starts one edge later, so no strobe is assigned twice in a step.
  // The optional capture pulse lands on the edge that commits a write.
  task automatic bus(input logic w, input logic [7:0] idx, input logic [15:0] wd,
                     input logic [3:0] cap, output logic [15:0] q);
    int n;
    n = 0;
    @(posedge clk);
    address   <= {idx, 2'b00};
    read      <= ~w;
    write     <= w;
    writedata <= {16'h0000, wd};
    do
    begin
      @(posedge clk);
      n++;
      capture_a <= (n == 1) ? cap : 4'h0;
    end
    while (waitrequest !== 1'b0);
    q = readdata[15:0];
    read  <= 1'b0;
    write <= 1'b0;
  endtask : bus

  task automatic wr(input logic [7:0] idx, input logic [15:0] wd);
    logic [15:0] d;
    bus(1'b1, idx, wd, 4'h0, d);
  endtask : wr

  task automatic rdreg(input logic [7:0] idx, output logic [15:0] q);
    bus(1'b0, idx, 16'h0000, 4'h0, q);
  endtask : rdreg

  task automatic cmp(input string name, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp)
    begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask : cmp

  task automatic pulse(input logic [3:0] a, input logic [3:0] b);
    @(posedge clk);
    capture_a <= a;
    capture_b <= b;
    @(posedge clk);
    capture_a <= 4'h0;
    capture_b <= 4'h0;
  endtask : pulse

  task automatic check_zero();
    for (int i = 0; i < 18; i++)
    begin
      rdreg(rows[i].idx, rd);
      cmp("reset value", 16'h0000, rd);
    end
    rdreg(timer_regs_pkg::IDX_MODE, rd);
    cmp("mode reset", 16'h0000, rd);
    cmp("irq reset", 16'h0000, {12'h000, irq});
  endtask : check_zero

  task automatic end_of_test();
    if (num_errors == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : end_of_test

  // ----------------------------------------
  // Watchdog
  // ----------------------------------------
  // The whole sequence needs well under a thousand cycles.
  initial
  begin
    repeat (5000) @(posedge clk);
    num_errors++;
    end_of_test();
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    clk = 1'b0;
    rst_b = 1'b0;
    address = 10'h000;
    read = 1'b0;
    write = 1'b0;
    writedata = 32'h00000000;
    byteenable = 4'hf;
    capture_a = 4'h0;
    capture_b = 4'h0;
    num_errors = 0;
    n_compared = 0;
    rows = '{
      '{timer_regs_pkg::IDX_EN,      16'ha5c3, 16'ha5c3},
      '{timer_regs_pkg::IDX_FLAGS,   16'hffff, 16'h0000},
      '{timer_regs_pkg::IDX_PS_A,    16'h1234, 16'h1234},
      '{timer_regs_pkg::IDX_PS_B,    16'h0003, 16'h0003},
      '{timer_regs_pkg::IDX_CNT[0],  16'h0042, 16'h0042},
      '{timer_regs_pkg::IDX_CNT[1],  16'h0777, 16'h0777},
      '{timer_regs_pkg::IDX_CNT[2],  16'h0000, 16'h0000},
      '{timer_regs_pkg::IDX_CNT[3],  16'h0000, 16'h0000},
      '{timer_regs_pkg::IDX_PER[0],  16'h1111, 16'h1111},
      '{timer_regs_pkg::IDX_PER[1],  16'h2222, 16'h2222},
      '{timer_regs_pkg::IDX_PER[2],  16'h3333, 16'h3333},
      '{timer_regs_pkg::IDX_PER[3],  16'h4444, 16'h4444},
      '{timer_regs_pkg::IDX_DUTY[0], 16'h5555, 16'h5555},
      '{timer_regs_pkg::IDX_DUTY[1], 16'h6666, 16'h6666},
      '{timer_regs_pkg::IDX_DUTY[2], 16'h7777, 16'h7777},
      '{timer_regs_pkg::IDX_DUTY[3], 16'h8888, 16'h8888},
      '{8'h81,                       16'hbeef, 16'h0000},
      '{8'hff,                       16'hbeef, 16'h0000}
    };
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    check_zero();
    // all subsystems in capture mode and stopped
    wr(timer_regs_pkg::IDX_MODE, 16'hcccc);
    for (int i = 0; i < 18; i++)
    begin
      wr(rows[i].idx, rows[i].wd);
      rdreg(rows[i].idx, rd);
      cmp("register readback", rows[i].ex, rd);
    end
    // Captures with every enable cleared: flags set, no request
    wr(timer_regs_pkg::IDX_EN, 16'h0000);
    pulse(4'h1, 4'h2);
    rdreg(timer_regs_pkg::IDX_PER[0], rd);
    cmp("period capture 1", 16'h0042, rd);
    rdreg(timer_regs_pkg::IDX_DUTY[1], rd);
    cmp("duty capture 2", 16'h0777, rd);
    rdreg(timer_regs_pkg::IDX_FLAGS, rd);
    cmp("flags after capture", 16'h0021, rd);
    cmp("irq masked", 16'h0000, {12'h000, irq});
    wr(timer_regs_pkg::IDX_EN, 16'h0020);
    rdreg(timer_regs_pkg::IDX_FLAGS, rd);
    cmp("irq enabled", 16'h0002, {12'h000, irq});
    // Clear-all write collides with a new capture on subsystem 2
    bus(1'b1, timer_regs_pkg::IDX_FLAGS, 16'hffff, 4'h2, rd);
    rdreg(timer_regs_pkg::IDX_FLAGS, rd);
    cmp("set beats clear", 16'h0010, rd);
    rdreg(timer_regs_pkg::IDX_EN, rd);
    cmp("enable untouched", 16'h0020, rd);
    cmp("irq per bit", 16'h0000, {12'h000, irq});
    rdreg(timer_regs_pkg::IDX_PER[1], rd);
    cmp("period capture 2", 16'h0777, rd);
    // Subsystem 1 high run bit only, 3 divides by 4, 4 divides by 1
    wr(timer_regs_pkg::IDX_MODE, 16'hdd8e);
    rdreg(timer_regs_pkg::IDX_CNT[2], x3);
    rdreg(timer_regs_pkg::IDX_CNT[3], x4);
    // Latch points of the two read pairs lie exactly 40 cycles apart
    repeat (34) @(posedge clk);
    rdreg(timer_regs_pkg::IDX_CNT[2], y3);
    rdreg(timer_regs_pkg::IDX_CNT[3], y4);
    cmp("count step divide 4", x3 + 16'h000a, y3);
    cmp("count step divide 1", x4 + 16'h0028, y4);
    rdreg(timer_regs_pkg::IDX_CNT[0], rd);
    cmp("high run bit ignored", 16'h0042, rd);
    // subsystem 2 in 16-bit PWM, set up while stopped
    wr(timer_regs_pkg::IDX_PS_A, 16'h0000);
    wr(timer_regs_pkg::IDX_CNT[1], 16'h0000);
    wr(timer_regs_pkg::IDX_PER[1], 16'h0020);
    wr(timer_regs_pkg::IDX_DUTY[1], 16'h0010);
    wr(timer_regs_pkg::IDX_FLAGS, 16'hffff);
    wr(timer_regs_pkg::IDX_MODE, 16'hdd9e);
    repeat (100) @(posedge clk);
    rdreg(timer_regs_pkg::IDX_FLAGS, rd);
    cmp("pwm match flags", 16'h0030, rd & 16'h00f0);
    wr(timer_regs_pkg::IDX_PER[1], 16'h0100);
    rdreg(timer_regs_pkg::IDX_PER[1], rd);
    cmp("period read running", 16'h0100, rd);
    wr(timer_regs_pkg::IDX_DUTY[1], 16'h0080);
    rdreg(timer_regs_pkg::IDX_DUTY[1], rd);
    cmp("duty read running", 16'h0080, rd);
    rdreg(timer_regs_pkg::IDX_FLAGS, rd);
    cmp("irq from pwm", 16'h0002, {12'h000, irq});
    // Second reset in mid-run
    @(posedge clk);
    rst_b <= 1'b0;
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    check_zero();
    end_of_test();
  end

endmodule : tb_top
